// >>> hvp_device.sv
`timescale 1ns/100ps
`default_nettype none
module hvp_device #(
  parameter int         FPAGE_W   = hvp_pkg::FLASH_PAGE_W,
  parameter int         FPAGES    = hvp_pkg::FLASH_PAGES,
  parameter int         EPAGE_W   = hvp_pkg::EE_PAGE_W,
  parameter int         EBYTES    = hvp_pkg::EE_BYTES,
  parameter int         FLASH_CYC = hvp_pkg::FLASH_PROG_CYC,
  parameter int         EE_CYC    = hvp_pkg::EE_PROG_CYC,
  parameter int         FUSE_CYC  = hvp_pkg::FUSE_PROG_CYC,
  // Identification and calibration values are arbitrary
  parameter logic [7:0] SIG0      = 8'h5a,
  parameter logic [7:0] SIG1      = 8'h3c,
  parameter logic [7:0] SIG2      = 8'h0f,
  parameter logic [7:0] CAL       = 8'h80
) (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  hvp_if.dev        pins,
  output logic [7:0] o_fuse_lo,
  output logic [7:0] o_fuse_hi,
  output logic [7:0] o_fuse_ext,
  output logic [7:0] o_lock
);
  localparam int FA_W  = FPAGE_W + $clog2(FPAGES);
  localparam int EA_W  = $clog2(EBYTES);
  localparam int FPW   = 1 << FPAGE_W;
  localparam int EPW   = 1 << EPAGE_W;
  localparam int FWRDS = FPAGES * FPW;

  if (FPAGE_W < 1 || FPAGE_W > 8 || FA_W > 16 || EPAGE_W < 1 || EA_W > 16
      || EPAGE_W >= EA_W || (1 << EA_W) != EBYTES || (1 << $clog2(FPAGES)) != FPAGES
      || FLASH_CYC < 1 || EE_CYC < 1 || FUSE_CYC < 1) begin : g_bad_param
    $error("hvp_device: unsupported geometry or timing");
  end

  // Bits: data[7:0] xtal[8] page_load_strobe[9] wr_n[10] oe_n[11] bs2[12] bs1[13] xa0[14] xa1[15]
  logic [15:0] s, prev_r;
  hvp_sync #(.W(16), .RST(16'h0c00)) u_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_d       ({pins.action_sel_hi, pins.action_sel_lo, pins.byte_select_one,
                 pins.byte_select_two, pins.out_enable_n, pins.write_n,
                 pins.page_load_strobe, pins.crystal_strobe_in, pins.bus}),
    .o_q       (s)
  );

  logic [7:0] din;
  logic [1:0] act;
  logic       bs1, bs2, xtal_rise, page_load_strobe_rise, wr_fall;
  assign din        = s[7:0];
  assign act        = s[15:14];
  assign bs1        = s[13];
  assign bs2        = s[12];
  assign xtal_rise  = s[8] & ~prev_r[8];
  assign page_load_strobe_rise = s[9] & ~prev_r[9];
  assign wr_fall    = ~s[10] & prev_r[10];

  logic [7:0]  cmd_r, cmd_nxt, dlo_r, dlo_nxt, dhi_r, dhi_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [7:0]  flo_r, flo_nxt, fhi_r, fhi_nxt, fex_r, fex_nxt, lock_r, lock_nxt;
  logic [15:0] fbuf_r [FPW],   fbuf_nxt [FPW];
  logic [FPW-1:0] fval_r, fval_nxt;
  logic [7:0]  ebuf_r [EPW],   ebuf_nxt [EPW];
  logic [EPW-1:0] eval_r, eval_nxt;
  logic [15:0] flash_r [FWRDS], flash_nxt [FWRDS];
  logic [7:0]  ee_r [EBYTES],  ee_nxt [EBYTES];
  logic [7:0]  dout_r, dout_nxt;
  logic        doe_r, rdy_r;

  logic [FA_W-1:0]    fidx;
  logic [FPAGE_W-1:0] fword;
  logic [EA_W-1:0]    eidx;
  logic [EPAGE_W-1:0] eword;
  logic               mode3;
  assign fidx  = addr_r[FA_W-1:0];
  assign fword = addr_r[FPAGE_W-1:0];
  assign eidx  = addr_r[EA_W-1:0];
  assign eword = addr_r[EPAGE_W-1:0];
  assign mode3 = (lock_r[hvp_pkg::LOCK_MODE_LSB +: 2] == 2'b00);

  always_comb begin
    cmd_nxt   = cmd_r;
    addr_nxt  = addr_r;
    dlo_nxt   = dlo_r;
    dhi_nxt   = dhi_r;
    cnt_nxt   = cnt_r;
    flo_nxt   = flo_r;
    fhi_nxt   = fhi_r;
    fex_nxt   = fex_r;
    lock_nxt  = lock_r;
    fbuf_nxt  = fbuf_r;
    fval_nxt  = fval_r;
    ebuf_nxt  = ebuf_r;
    eval_nxt  = eval_r;
    flash_nxt = flash_r;
    ee_nxt    = ee_r;
    if (cnt_r != 32'h0) begin
      cnt_nxt = cnt_r - 32'h1;
    end else if (xtal_rise) begin
      unique case (act)
        hvp_pkg::ACT_ADDR: begin
          if (bs1) addr_nxt[15:8] = din;
          else     addr_nxt[7:0]  = din;
        end
        hvp_pkg::ACT_DATA: begin
          if (bs1) dhi_nxt = din;
          else     dlo_nxt = din;
        end
        hvp_pkg::ACT_CMD: begin
          cmd_nxt = din;
          if (din == hvp_pkg::CMD_NOP) begin
            fval_nxt = '0;
            eval_nxt = '0;
          end
        end
        hvp_pkg::ACT_IDLE: begin
        end
      endcase
    end else if (page_load_strobe_rise) begin
      if (cmd_r == hvp_pkg::CMD_WR_FLASH && bs1) begin
        fbuf_nxt[fword] = {dhi_r, dlo_r};
        fval_nxt[fword] = 1'b1;
      end else if (cmd_r == hvp_pkg::CMD_WR_EE) begin
        ebuf_nxt[eword] = dlo_r;
        eval_nxt[eword] = 1'b1;
      end
    end else if (wr_fall) begin
      unique case (cmd_r)
        hvp_pkg::CMD_WR_FLASH: begin
          // Only words latched since the last page write are altered
          for (int i = 0; i < FPW; i++) begin
            if (fval_r[i]) begin
              flash_nxt[{fidx[FA_W-1:FPAGE_W], FPAGE_W'(i)}] = fbuf_r[i];
            end
          end
          fval_nxt = '0;
          cnt_nxt  = 32'(FLASH_CYC);
        end
        hvp_pkg::CMD_WR_EE: begin
          if (!bs1) begin
            for (int i = 0; i < EPW; i++) begin
              if (eval_r[i]) begin
                ee_nxt[{eidx[EA_W-1:EPAGE_W], EPAGE_W'(i)}] = ebuf_r[i];
              end
            end
            eval_nxt = '0;
            cnt_nxt  = 32'(EE_CYC);
          end
        end
        hvp_pkg::CMD_WR_FUSE: begin
          if (bs1 && !bs2)      fhi_nxt = dlo_r;
          else if (!bs1 && bs2) fex_nxt = dlo_r;
          else if (!bs1)        flo_nxt = dlo_r;
          cnt_nxt = 32'(FUSE_CYC);
        end
        hvp_pkg::CMD_WR_LOCK: begin
          // Cells only go to 0; with mode 3 the boot bits are frozen
          lock_nxt = lock_r & (dlo_r | (mode3 ? hvp_pkg::LOCK_BOOT_MSK : 8'h00));
          cnt_nxt  = 32'(FUSE_CYC);
        end
        default: begin
        end
      endcase
    end
  end

  always_comb begin
    dout_nxt = hvp_pkg::ERASED_BYTE;
    unique case (cmd_r)
      hvp_pkg::CMD_RD_FLASH: dout_nxt = bs1 ? flash_r[fidx][15:8] : flash_r[fidx][7:0];
      hvp_pkg::CMD_RD_EE:    dout_nxt = ee_r[eidx];
      hvp_pkg::CMD_RD_FUSE: begin
        unique case ({bs2, bs1})
          2'b00: dout_nxt = flo_r;
          2'b11: dout_nxt = fhi_r;
          2'b10: dout_nxt = fex_r;
          2'b01: dout_nxt = lock_r;
        endcase
      end
      hvp_pkg::CMD_RD_SIG: begin
        if (bs1) begin
          if (addr_r[7:0] == 8'h00) dout_nxt = CAL;
        end else begin
          unique case (addr_r[7:0])
            8'h00:   dout_nxt = SIG0;
            8'h01:   dout_nxt = SIG1;
            8'h02:   dout_nxt = SIG2;
            default: dout_nxt = hvp_pkg::ERASED_BYTE;
          endcase
        end
      end
      default: dout_nxt = hvp_pkg::ERASED_BYTE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prev_r <= 16'h0c00;
      cmd_r  <= hvp_pkg::CMD_NOP;
      addr_r <= 16'h0000;
      dlo_r  <= 8'h00;
      dhi_r  <= 8'h00;
      cnt_r  <= 32'h0;
      flo_r  <= hvp_pkg::FUSE_LO_RST;
      fhi_r  <= hvp_pkg::FUSE_HI_RST;
      fex_r  <= hvp_pkg::FUSE_EX_RST;
      lock_r <= hvp_pkg::LOCK_RST;
      fval_r <= '0;
      eval_r <= '0;
      for (int i = 0; i < FPW; i++) fbuf_r[i] <= hvp_pkg::ERASED_WORD;
      for (int i = 0; i < EPW; i++) ebuf_r[i] <= hvp_pkg::ERASED_BYTE;
      for (int i = 0; i < FWRDS; i++) flash_r[i] <= hvp_pkg::ERASED_WORD;
      for (int i = 0; i < EBYTES; i++) ee_r[i] <= hvp_pkg::ERASED_BYTE;
      dout_r <= hvp_pkg::ERASED_BYTE;
      doe_r  <= 1'b0;
      rdy_r  <= 1'b1;
    end else begin
      prev_r  <= s;
      cmd_r   <= cmd_nxt;
      addr_r  <= addr_nxt;
      dlo_r   <= dlo_nxt;
      dhi_r   <= dhi_nxt;
      cnt_r   <= cnt_nxt;
      flo_r   <= flo_nxt;
      fhi_r   <= fhi_nxt;
      fex_r   <= fex_nxt;
      lock_r  <= lock_nxt;
      fval_r  <= fval_nxt;
      eval_r  <= eval_nxt;
      fbuf_r  <= fbuf_nxt;
      ebuf_r  <= ebuf_nxt;
      flash_r <= flash_nxt;
      ee_r    <= ee_nxt;
      dout_r  <= dout_nxt;
      doe_r   <= ~s[11];
      rdy_r   <= (cnt_nxt == 32'h0);
    end
  end

  assign pins.bus_dev        = dout_r;
  assign pins.bus_dev_oe     = doe_r;
  assign pins.ready_busy_out = rdy_r;
  assign o_fuse_lo           = flo_r;
  assign o_fuse_hi           = fhi_r;
  assign o_fuse_ext          = fex_r;
  assign o_lock              = lock_r;
endmodule : hvp_device
`default_nettype wire

// >>> hvp_pkg.sv
package hvp_pkg;
  localparam int CLK_PERIOD_NS = 20;
  // Action codes on {action_sel_hi, action_sel_lo}
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD  = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;
  // Command bytes
  localparam logic [7:0] CMD_NOP      = 8'h00;
  localparam logic [7:0] CMD_WR_FUSE  = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK  = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE    = 8'h11;
  localparam logic [7:0] CMD_RD_SIG   = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE  = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE    = 8'h03;
  // Lock byte fields
  localparam int         LOCK_MODE_LSB = 0;
  localparam logic [7:0] LOCK_BOOT_MSK = 8'h3c;
  // Reset values of the nonvolatile cells
  localparam logic [7:0]  FUSE_LO_RST = 8'hff;
  localparam logic [7:0]  FUSE_HI_RST = 8'hff;
  localparam logic [7:0]  FUSE_EX_RST = 8'hff;
  localparam logic [7:0]  LOCK_RST    = 8'hff;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam logic [7:0]  ERASED_BYTE = 8'hff;
  // Geometry
  localparam int FLASH_PAGE_W = 6;
  localparam int FLASH_PAGES  = 8;
  localparam int EE_PAGE_W    = 2;
  localparam int EE_BYTES     = 512;
  // Programming times and derived cycle counts
  localparam int FLASH_PROG_US = 2600;
  localparam int EE_PROG_US    = 3600;
  localparam int FUSE_PROG_US  = 4500;
  localparam int FLASH_PROG_CYC = FLASH_PROG_US * 1000 / CLK_PERIOD_NS;
  localparam int EE_PROG_CYC    = EE_PROG_US * 1000 / CLK_PERIOD_NS;
  localparam int FUSE_PROG_CYC  = FUSE_PROG_US * 1000 / CLK_PERIOD_NS;
  // Programmer pin timing
  localparam int SETUP_NS  = 80;
  localparam int PULSE_NS  = 80;
  localparam int HOLD_NS   = 200;
  localparam int SAMPLE_NS = 160;
  localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC  = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SAMPLE_CYC = (SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Host register map and fields
  localparam logic [7:0] REG_PINS = 8'h00;
  localparam logic [7:0] REG_GO   = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam int PINS_BS1 = 8;
  localparam int PINS_BS2 = 9;
  localparam int PINS_ACT = 10;
  localparam logic [1:0] OP_XTAL  = 2'h0;
  localparam logic [1:0] OP_PAGE_LOAD_STROBE = 2'h1;
  localparam logic [1:0] OP_WR    = 2'h2;
  localparam logic [1:0] OP_READ  = 2'h3;
  typedef enum logic [2:0] {HS_IDLE, HS_WAIT, HS_SETUP, HS_PULSE, HS_READ, HS_HOLD} hvp_hstate_t;
endpackage : hvp_pkg

// >>> hvp_if.sv
`timescale 1ns/100ps
`default_nettype none
interface hvp_if;
  logic       action_sel_hi;
  logic       action_sel_lo;
  logic       byte_select_one;
  logic       byte_select_two;
  logic       page_load_strobe;
  logic       crystal_strobe_in;
  logic       write_n;
  logic       out_enable_n;
  logic       ready_busy_out;
  logic [7:0] bus_host;
  logic       bus_host_oe;
  logic [7:0] bus_dev;
  logic       bus_dev_oe;
  logic [7:0] bus;
  // Undriven bus floats high through the pin pull-ups
  assign bus = bus_dev_oe ? bus_dev : (bus_host_oe ? bus_host : 8'hff);
  modport dev (input action_sel_hi, action_sel_lo, byte_select_one, byte_select_two,
               page_load_strobe, crystal_strobe_in, write_n, out_enable_n, bus,
               output ready_busy_out, bus_dev, bus_dev_oe);
  modport host (output action_sel_hi, action_sel_lo, byte_select_one, byte_select_two,
                page_load_strobe, crystal_strobe_in, write_n, out_enable_n,
                bus_host, bus_host_oe, input ready_busy_out, bus);
endinterface : hvp_if
`default_nettype wire

// >>> hvp_sync.sv
`timescale 1ns/100ps
`default_nettype none
module hvp_sync #(
  parameter int             W   = 1,
  parameter logic [W-1:0]   RST = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] s1_r, s2_r, s3_r, q_r, q_nxt;

  // A change counts only once stages two and three agree
  always_comb begin
    for (int b = 0; b < W; b++) begin
      q_nxt[b] = (s2_r[b] == s3_r[b]) ? s3_r[b] : q_r[b];
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_r <= RST;
      s2_r <= RST;
      s3_r <= RST;
      q_r  <= RST;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      q_r  <= q_nxt;
    end
  end

  assign o_q = q_r;
endmodule : hvp_sync
`default_nettype wire

// >>> hvp_host.sv
`timescale 1ns/100ps
`default_nettype none
module hvp_host (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  hvp_if.host              pins
);
  logic rdy_s;
  hvp_sync #(.W(1), .RST(1'b1)) u_rdy_sync (
    .i_clk     (i_clk),
    .i_reset_n (i_reset_n),
    .i_d       (pins.ready_busy_out),
    .o_q       (rdy_s)
  );

  hvp_pkg::hvp_hstate_t st_r, st_nxt;
  logic [11:0] pins_r, pins_nxt;
  logic [1:0]  op_r, op_nxt;
  logic [7:0]  cnt_r, cnt_nxt, rdat_r, rdat_nxt;
  logic        xtal_r, xtal_nxt, page_load_strobe_r, page_load_strobe_nxt, wr_n_r, wr_n_nxt, oe_n_r, oe_n_nxt;
  logic        hoe_r, hoe_nxt, wpend_r, wpend_nxt;
  logic [7:0]  waddr_r, waddr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic        aphase;

  assign aphase = i_hsel & i_htrans[1] & i_hready;

  always_comb begin
    st_nxt     = st_r;
    pins_nxt   = pins_r;
    op_nxt     = op_r;
    cnt_nxt    = cnt_r;
    rdat_nxt   = rdat_r;
    xtal_nxt   = xtal_r;
    page_load_strobe_nxt  = page_load_strobe_r;
    wr_n_nxt   = wr_n_r;
    oe_n_nxt   = oe_n_r;
    hoe_nxt    = hoe_r;
    wpend_nxt  = aphase & i_hwrite;
    waddr_nxt  = aphase ? i_haddr[7:0] : waddr_r;
    hrdata_nxt = hrdata_r;
    if (aphase && !i_hwrite) begin
      unique case (i_haddr[7:0])
        hvp_pkg::REG_PINS: hrdata_nxt = {20'h0, pins_r};
        hvp_pkg::REG_STAT: hrdata_nxt = {16'h0, rdat_r, 6'h0, rdy_s, st_r != hvp_pkg::HS_IDLE};
        default:           hrdata_nxt = 32'h0;
      endcase
    end
    if (wpend_r && waddr_r == hvp_pkg::REG_PINS) pins_nxt = i_hwdata[11:0];
    unique case (st_r)
      hvp_pkg::HS_IDLE: begin
        // A new order is refused while one is still running
        if (wpend_r && waddr_r == hvp_pkg::REG_GO) begin
          op_nxt = i_hwdata[1:0];
          st_nxt = hvp_pkg::HS_WAIT;
        end
      end
      hvp_pkg::HS_WAIT: begin
        if (rdy_s) begin
          st_nxt  = hvp_pkg::HS_SETUP;
          cnt_nxt = 8'(hvp_pkg::SETUP_CYC);
        end
      end
      hvp_pkg::HS_SETUP: begin
        cnt_nxt = cnt_r - 8'h1;
        if (cnt_r == 8'h1) begin
          if (op_r == hvp_pkg::OP_READ) begin
            st_nxt   = hvp_pkg::HS_READ;
            cnt_nxt  = 8'(hvp_pkg::SAMPLE_CYC);
            oe_n_nxt = 1'b0;
            hoe_nxt  = 1'b0;
          end else begin
            st_nxt    = hvp_pkg::HS_PULSE;
            cnt_nxt   = 8'(hvp_pkg::PULSE_CYC);
            xtal_nxt  = (op_r == hvp_pkg::OP_XTAL);
            page_load_strobe_nxt = (op_r == hvp_pkg::OP_PAGE_LOAD_STROBE);
            wr_n_nxt  = (op_r != hvp_pkg::OP_WR);
          end
        end
      end
      hvp_pkg::HS_PULSE: begin
        cnt_nxt = cnt_r - 8'h1;
        if (cnt_r == 8'h1) begin
          xtal_nxt  = 1'b0;
          page_load_strobe_nxt = 1'b0;
          wr_n_nxt  = 1'b1;
          st_nxt    = hvp_pkg::HS_HOLD;
          cnt_nxt   = 8'(hvp_pkg::HOLD_CYC);
        end
      end
      hvp_pkg::HS_READ: begin
        cnt_nxt = cnt_r - 8'h1;
        if (cnt_r == 8'h1) begin
          rdat_nxt = pins.bus;
          oe_n_nxt = 1'b1;
          st_nxt   = hvp_pkg::HS_HOLD;
          cnt_nxt  = 8'(hvp_pkg::HOLD_CYC);
        end
      end
      hvp_pkg::HS_HOLD: begin
        // Hold also lets the device release the bus and drop ready first
        cnt_nxt = cnt_r - 8'h1;
        if (cnt_r == 8'h1) begin
          hoe_nxt = 1'b1;
          st_nxt  = hvp_pkg::HS_IDLE;
        end
      end
      default: st_nxt = hvp_pkg::HS_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_r     <= hvp_pkg::HS_IDLE;
      pins_r   <= {hvp_pkg::ACT_IDLE, 10'h0};
      op_r     <= hvp_pkg::OP_XTAL;
      cnt_r    <= 8'h0;
      rdat_r   <= 8'h0;
      xtal_r   <= 1'b0;
      page_load_strobe_r  <= 1'b0;
      wr_n_r   <= 1'b1;
      oe_n_r   <= 1'b1;
      hoe_r    <= 1'b1;
      wpend_r  <= 1'b0;
      waddr_r  <= 8'h0;
      hrdata_r <= 32'h0;
    end else begin
      st_r     <= st_nxt;
      pins_r   <= pins_nxt;
      op_r     <= op_nxt;
      cnt_r    <= cnt_nxt;
      rdat_r   <= rdat_nxt;
      xtal_r   <= xtal_nxt;
      page_load_strobe_r  <= page_load_strobe_nxt;
      wr_n_r   <= wr_n_nxt;
      oe_n_r   <= oe_n_nxt;
      hoe_r    <= hoe_nxt;
      wpend_r  <= wpend_nxt;
      waddr_r  <= waddr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  assign o_hrdata               = hrdata_r;
  assign o_hreadyout            = 1'b1;
  assign o_hresp                = 1'b0;
  assign pins.bus_host          = pins_r[7:0];
  assign pins.bus_host_oe       = hoe_r;
  assign pins.byte_select_one   = pins_r[hvp_pkg::PINS_BS1];
  assign pins.byte_select_two   = pins_r[hvp_pkg::PINS_BS2];
  assign pins.action_sel_lo     = pins_r[hvp_pkg::PINS_ACT];
  assign pins.action_sel_hi     = pins_r[hvp_pkg::PINS_ACT + 1];
  assign pins.crystal_strobe_in = xtal_r;
  assign pins.page_load_strobe  = page_load_strobe_r;
  assign pins.write_n           = wr_n_r;
  assign pins.out_enable_n      = oe_n_r;
endmodule : hvp_host
`default_nettype wire

// >>> hvp_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module hvp_monitor #(
  parameter int BUSY_CYC = 20
) (
  input wire logic       i_clk,
  input wire logic       i_reset_n,
  input wire logic       action_sel_hi,
  input wire logic       action_sel_lo,
  input wire logic       byte_select_one,
  input wire logic       byte_select_two,
  input wire logic       page_load_strobe,
  input wire logic       crystal_strobe_in,
  input wire logic       write_n,
  input wire logic       out_enable_n,
  input wire logic       ready_busy_out,
  input wire logic [7:0] bus_host,
  input wire logic       bus_host_oe,
  input wire logic [7:0] bus_dev,
  input wire logic       bus_dev_oe
);
  logic [15:0] busy_cnt_r;
  logic [15:0] busy_cnt_nxt;
  always_comb busy_cnt_nxt = ready_busy_out ? 16'h0 : busy_cnt_r + 16'h1;
  always_ff @(posedge i_clk or negedge i_reset_n)
    if (!i_reset_n) busy_cnt_r <= 16'h0;
    else busy_cnt_r <= busy_cnt_nxt;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // Single-cycle glitches would be dropped by the synchroniser, which needs stages two and three to agree
  sequence s_held4(x);
    x[*4] ##1 !x;
  endsequence
  a_xtal_pulse: assert property ($rose(crystal_strobe_in) |-> s_held4(crystal_strobe_in))
    else $error("crystal strobe pulse width wrong");
  a_page_load_strobe_pulse: assert property ($rose(page_load_strobe) |-> s_held4(page_load_strobe))
    else $error("page load pulse width wrong");
  a_wr_pulse: assert property ($fell(write_n) |-> s_held4(!write_n))
    else $error("write pulse width wrong");
  a_strobe_setup: assert property (crystal_strobe_in |-> bus_host_oe &&
    $stable({action_sel_hi, action_sel_lo, byte_select_one, byte_select_two, bus_host}))
    else $error("selects moved during crystal strobe");
  a_no_contend: assert property (!out_enable_n |-> !bus_host_oe)
    else $error("host drives bus while output enabled");
  a_oe_answer: assert property ($fell(out_enable_n) |-> ##[1:7] bus_dev_oe)
    else $error("device did not drive bus");
  a_oe_release: assert property (out_enable_n[*8] |-> !bus_dev_oe)
    else $error("device drives bus without output enable");
  a_busy_start: assert property ($fell(write_n) && ready_busy_out && !byte_select_one
    |-> ##[1:8] !ready_busy_out)
    else $error("busy did not start after write strobe");
  a_busy_len: assert property ($rose(ready_busy_out) |->
    busy_cnt_r >= BUSY_CYC - 1 && busy_cnt_r <= BUSY_CYC + 1)
    else $error("busy length wrong");
endmodule : hvp_monitor
`default_nettype wire

// >>> test_parallel_hv_program_port.sv
`timescale 1ns/100ps
`default_nettype none
module test_parallel_hv_program_port;
  logic        i_clk = 1'b0;
  logic        i_reset_n = 1'b0;
  logic        hsel, hwrite, hready, hresp, got_v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rdata, got;
  logic [31:0] q[$];
  logic [15:0] fd[2];
  logic [7:0]  ed, fv[3];
  logic [7:0]  flo, fhi, fex, lck;
  logic [1:0]  wsel[3] = '{2'h0, 2'h1, 2'h2};
  logic [1:0]  rsel[3] = '{2'h0, 2'h3, 2'h2};
  logic [7:0]  lk[3] = '{8'hfc, 8'hc0, 8'hff};
  // Identification and calibration values are arbitrary
  logic [7:0]  sig[4] = '{8'h5a, 8'h3c, 8'h0f, 8'h6d};
  int          n_mismatch = 0, compares = 0, cyc = 0, k;
  logic [31:0] seed;
  always #(hvp_pkg::CLK_PERIOD_NS / 2) i_clk = ~i_clk;
  hvp_if u_hvp_if();
  hvp_host u_hvp_host(.i_clk(i_clk), .i_reset_n(i_reset_n), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .pins(u_hvp_if.host));
  hvp_device #(.FLASH_CYC(20), .EE_CYC(20), .FUSE_CYC(20), .CAL(8'h6d)) u_hvp_device(
    .i_clk(i_clk), .i_reset_n(i_reset_n), .pins(u_hvp_if.dev), .o_fuse_lo(flo),
    .o_fuse_hi(fhi), .o_fuse_ext(fex), .o_lock(lck));
  hvp_monitor #(.BUSY_CYC(20)) u_hvp_monitor(.i_clk(i_clk), .i_reset_n(i_reset_n),
    .action_sel_hi(u_hvp_if.action_sel_hi), .action_sel_lo(u_hvp_if.action_sel_lo),
    .byte_select_one(u_hvp_if.byte_select_one), .byte_select_two(u_hvp_if.byte_select_two),
    .page_load_strobe(u_hvp_if.page_load_strobe), .crystal_strobe_in(u_hvp_if.crystal_strobe_in),
    .write_n(u_hvp_if.write_n), .out_enable_n(u_hvp_if.out_enable_n),
    .ready_busy_out(u_hvp_if.ready_busy_out), .bus_host(u_hvp_if.bus_host),
    .bus_host_oe(u_hvp_if.bus_host_oe), .bus_dev(u_hvp_if.bus_dev),
    .bus_dev_oe(u_hvp_if.bus_dev_oe));
  task results;
    $display("comparisons %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task check(input logic [31:0] v, input logic [31:0] e);
    compares++;
    if (v !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, v, e);
    end
  endtask : check
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= w; hsize <= 3'h2;
    @(posedge i_clk);
    while (hready !== 1'b1) @(posedge i_clk);
    htrans <= 2'h0; hwdata <= d;
    @(posedge i_clk);
    while (hready !== 1'b1) @(posedge i_clk);
    rdata = hrdata;
  endtask : ahb
  task note(input logic [31:0] v, input logic [31:0] e);
    q.push_back(e); got <= v; got_v <= 1'b1;
    @(posedge i_clk);
    got_v <= 1'b0;
  endtask : note
  // The host sequencer waits for ready itself, so a page is never overrun
  task op(input logic [1:0] act, input logic [1:0] bs, input logic [7:0] b, input logic [1:0] go);
    ahb(1'b1, hvp_pkg::REG_PINS, {20'h0, act, bs, b});
    ahb(1'b1, hvp_pkg::REG_GO, {30'h0, go});
    repeat (3) @(posedge i_clk);
    rdata = 32'h1;
    while (rdata[0] === 1'b1) ahb(1'b0, hvp_pkg::REG_STAT, 32'h0);
  endtask : op
  task cmd(input logic [7:0] c); op(hvp_pkg::ACT_CMD, 2'h0, c, hvp_pkg::OP_XTAL); endtask : cmd
  task adr(input logic [1:0] bs, input logic [7:0] b);
    op(hvp_pkg::ACT_ADDR, bs, b, hvp_pkg::OP_XTAL);
  endtask : adr
  task dat(input logic [1:0] bs, input logic [7:0] b);
    op(hvp_pkg::ACT_DATA, bs, b, hvp_pkg::OP_XTAL);
  endtask : dat
  task pul(input logic [1:0] bs, input logic [1:0] go);
    op(hvp_pkg::ACT_IDLE, bs, 8'h00, go);
  endtask : pul
  task rd(input logic [1:0] bs, input logic [7:0] e);
    pul(bs, hvp_pkg::OP_READ);
    ahb(1'b0, hvp_pkg::REG_STAT, 32'h0);
    note({24'h0, rdata[15:8]}, {24'h0, e});
  endtask : rd
  always @(posedge i_clk) if (got_v === 1'b1) check(got, q.pop_front());
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      results();
    end
  end
  initial begin
    seed = 32'hc9ee3c8a;
    hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0; got = 0; got_v = 0;
    repeat (10) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (5) @(posedge i_clk);
    ahb(1'b0, hvp_pkg::REG_PINS, 32'h0); note(rdata, 32'h0000_0c00);
    ahb(1'b0, 8'h0c, 32'h0); note(rdata | {31'h0, hresp}, 32'h0);
    $display("test registers done");
    cmd(hvp_pkg::CMD_WR_FLASH);
    for (k = 0; k < 2; k++) begin
      fd[k] = 16'($random(seed));
      adr(2'h0, {k[1:0], 6'h05});
      dat(2'h0, fd[k][7:0]);
      dat(2'h1, fd[k][15:8]);
      pul(2'h1, hvp_pkg::OP_PAGE_LOAD_STROBE);
      adr(2'h1, 8'h00);
      pul(2'h0, hvp_pkg::OP_WR);
    end
    cmd(hvp_pkg::CMD_NOP);
    cmd(hvp_pkg::CMD_RD_FLASH);
    for (k = 0; k < 2; k++) begin
      adr(2'h0, {k[1:0], 6'h05});
      rd(2'h0, fd[k][7:0]);
      rd(2'h1, fd[k][15:8]);
    end
    $display("test flash done");
    ed = 8'($random(seed));
    cmd(hvp_pkg::CMD_WR_EE);
    adr(2'h1, 8'h01);
    adr(2'h0, 8'h23);
    dat(2'h0, ed);
    pul(2'h0, hvp_pkg::OP_PAGE_LOAD_STROBE);
    pul(2'h0, hvp_pkg::OP_WR);
    cmd(hvp_pkg::CMD_RD_EE);
    rd(2'h0, ed);
    $display("test eeprom done");
    cmd(hvp_pkg::CMD_WR_FUSE);
    for (k = 0; k < 3; k++) begin
      fv[k] = 8'($random(seed));
      dat(2'h0, fv[k]);
      pul(wsel[k], hvp_pkg::OP_WR);
    end
    cmd(hvp_pkg::CMD_RD_FUSE);
    for (k = 0; k < 3; k++) rd(rsel[k], fv[k]);
    for (k = 0; k < 3; k++) begin
      cmd(hvp_pkg::CMD_WR_LOCK);
      dat(2'h0, lk[k]);
      pul(2'h0, hvp_pkg::OP_WR);
      cmd(hvp_pkg::CMD_RD_FUSE);
      rd(2'h1, 8'hfc);
    end
    @(posedge i_clk);
    note({flo, fhi, fex, lck}, {fv[0], fv[1], fv[2], 8'hfc});
    $display("test fuse and lock done");
    cmd(hvp_pkg::CMD_RD_SIG);
    for (k = 0; k < 3; k++) begin
      adr(2'h0, k[7:0]);
      rd(2'h0, sig[k]);
    end
    adr(2'h0, 8'h00);
    rd(2'h1, sig[3]);
    $display("test identification done");
    results();
  end
endmodule : test_parallel_hv_program_port
`default_nettype wire
